/* verilog/stmc_consts.svh */
// Purpose: Constants for the static memory controller
// Assumes: Included by its bare name
// Notes:   Offsets are byte addresses on the register port
`ifndef STMC_CONSTS_SVH
`define STMC_CONSTS_SVH

`define STMC_NUM_BANKS  4
`define STMC_STAT_OFS   8'h10
`define STMC_CFG_RESET  32'h008f_ffff
`define STMC_CFG_MASK   32'h00ff_ffff

`define STMC_F_RDW      0
`define STMC_F_WRW      5
`define STMC_F_BST      10
`define STMC_F_TA       15
`define STMC_F_BW16     19
`define STMC_F_DW16     20
`define STMC_F_WP       21
`define STMC_F_BROM     22
`define STMC_F_BLERD    23
`define STMC_W_WAIT     5
`define STMC_W_TA       4

`define STMC_HRESP_OK   2'b00
`define STMC_HRESP_ERR  2'b01
`define STMC_BLE_NONE   2'b11
`define STMC_BLE_ALL    2'b00
`define STMC_BLE_LO     2'b10
`define STMC_BLE_HI     2'b01
`define STMC_SZ_HALF    2'h1
`define STMC_SZ_WORD    2'h2
`define STMC_STRAP_LOAD 2'h2
`define STMC_STRAP_DONE 2'h3

`endif

/* verilog/stmc_pkg.sv */
// Purpose: Types for the static memory controller
// Assumes: Used with stmc_consts.svh
// Notes:   No constants live here
package stmc_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_TURN,
        S_SETUP,
        S_ACT,
        S_REL,
        S_CAP
    } stmc_state_e;

    typedef struct packed {
        logic [1:0]  bank;
        logic [1:0]  size;
        logic [23:0] addr;
        logic [31:0] data;
    } stmc_wbent_s;

endpackage : stmc_pkg

/* verilog/stmc_static_mem_ctrl.sv */
// Purpose: Static memory controller, system bus slave to external memory
// Assumes: Single clock; strap and wait pin are asynchronous
// Notes:   Bank config at 0x00..0x0c, status at 0x10
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "stmc_consts.svh"

module stmc_static_mem_ctrl #(
    parameter int WB_DEPTH = 4
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        boot_x8,
    input  wire logic [2:0]  cs_pin_en,
    input  wire logic        addr_hi_pin_en,
    output logic      [23:0] ext_addr,
    output logic      [15:0] ext_data_out,
    output logic             ext_data_oe_n,
    input  wire logic [15:0] ext_data_in,
    output logic      [3:0]  bank_select_n,
    output logic      [1:0]  byte_lane_n,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    input  wire logic        extend_wait_n
);

    localparam int PW = $clog2(WB_DEPTH);

    if (WB_DEPTH < 2 || (1 << PW) != WB_DEPTH) begin : g_chk
        $error("WB_DEPTH must be a power of two of at least 2");
    end

    stmc_pkg::stmc_state_e state_ff;
    stmc_pkg::stmc_state_e nxt_state;
    stmc_pkg::stmc_wbent_s wb_mem [WB_DEPTH];
    stmc_pkg::stmc_wbent_s head;

    logic [31:0]  cfg_ff [`STMC_NUM_BANKS];
    logic [31:0]  ecfg;
    logic         boot_s1_ff, boot_s2_ff, wait_s1_ff, wait_s2_ff;
    logic [1:0]   strap_cnt_ff;
    logic         cfg_hit, stat_hit;
    logic         ap_ok, ap_mis, ap_wp, ap_err;
    logic [1:0]   ap_bank;
    logic         err1_ff, err2_ff;
    logic         dp_wr_ff, dp_rd_ff;
    logic [23:0]  dp_addr_ff;
    logic [1:0]   dp_bank_ff, dp_size_ff;
    logic [PW-1:0] wb_wp_ff, wb_rp_ff;
    logic [PW:0]  wb_cnt_ff;
    logic         wb_full, push, pop;
    logic         cand_wr, cand_rd, need_ta;
    logic [1:0]   cand_bank;
    logic         last_vld_ff, last_wr_ff;
    logic [1:0]   last_bank_ff;
    logic         e_wr_ff;
    logic [1:0]   e_bank_ff, e_size_ff, e_part_ff, last_part;
    logic [23:0]  e_addr_ff;
    logic [31:0]  e_data_ff, rd_buf_ff;
    logic         rd_done_ff, bus16, part_done, wait_end, next_wr, cs_act;
    logic [4:0]   act_cnt_ff, wait_lim;
    logic [3:0]   ta_cnt_ff, ta_lim;
    logic [1:0]   wr_ble, rd_ble;

    // Strap and wait pin synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            boot_s1_ff <= 1'b0;
            boot_s2_ff <= 1'b0;
            wait_s1_ff <= 1'b1;
            wait_s2_ff <= 1'b1;
        end else begin
            boot_s1_ff <= boot_x8;
            boot_s2_ff <= boot_s1_ff;
            wait_s1_ff <= extend_wait_n;
            wait_s2_ff <= wait_s1_ff;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt_ff <= 2'h0;
        end else if (strap_cnt_ff != `STMC_STRAP_DONE) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
        end
    end

    assign cfg_hit  = reg_addr < `STMC_STAT_OFS && reg_addr[1:0] == 2'h0;
    assign stat_hit = reg_addr == `STMC_STAT_OFS;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `STMC_NUM_BANKS; i++) begin
                cfg_ff[i] <= `STMC_CFG_RESET;
            end
        end else begin
            if (strap_cnt_ff == `STMC_STRAP_LOAD) begin
                for (int i = 0; i < `STMC_NUM_BANKS; i++) begin
                    cfg_ff[i][`STMC_F_BW16] <= ~boot_s2_ff;
                end
            end
            if (reg_wr && cfg_hit) begin
                cfg_ff[reg_addr[3:2]] <= reg_wdata & `STMC_CFG_MASK;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd && cfg_hit) begin
            reg_rdata <= cfg_ff[reg_addr[3:2]];
        end else if (reg_rd && stat_hit) begin
            reg_rdata <= {24'h0, wb_cnt_ff[PW:0] == '0, 1'b0, 1'(state_ff != stmc_pkg::S_IDLE),
                          5'(wb_cnt_ff)};
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Only bits 27:26 and 23:0 are decoded
    assign ap_ok   = hsel && htrans[1] && hready;
    assign ap_bank = haddr[27:26];
    assign ap_mis  = (hsize == 3'h1 && haddr[0]) || (hsize == 3'h2 && haddr[1:0] == 2'b10) ||
                     hsize > 3'h2;
    assign ap_wp   = hwrite && cfg_ff[ap_bank][`STMC_F_WP];
    assign ap_err  = ap_ok && (ap_mis || ap_wp);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err1_ff <= 1'b0;
            err2_ff <= 1'b0;
        end else begin
            err1_ff <= ap_err;
            err2_ff <= err1_ff;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dp_wr_ff   <= 1'b0;
            dp_rd_ff   <= 1'b0;
            dp_addr_ff <= 24'h0;
            dp_bank_ff <= 2'h0;
            dp_size_ff <= 2'h0;
        end else if (ap_ok && !ap_err) begin
            dp_wr_ff   <= hwrite;
            dp_rd_ff   <= !hwrite;
            dp_addr_ff <= haddr[23:0];
            dp_bank_ff <= ap_bank;
            dp_size_ff <= hsize[1:0];
        end else begin
            if (push) begin
                dp_wr_ff <= 1'b0;
            end
            if (rd_done_ff) begin
                dp_rd_ff <= 1'b0;
            end
        end
    end

    // Writes stall only when buffer is full
    assign wb_full   = wb_cnt_ff == (PW + 1)'(WB_DEPTH);
    assign push      = dp_wr_ff && !wb_full;
    assign hreadyout = err2_ff || (!err1_ff && !(dp_wr_ff && wb_full) && !(dp_rd_ff && !rd_done_ff));
    assign hresp     = (err1_ff || err2_ff) ? `STMC_HRESP_ERR : `STMC_HRESP_OK;
    assign hrdata    = rd_buf_ff;

    // Write data taken in the data phase
    always_ff @(posedge clock) begin
        if (push) begin
            wb_mem[wb_wp_ff] <= '{bank: dp_bank_ff, size: dp_size_ff, addr: dp_addr_ff, data: hwdata};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_wp_ff  <= '0;
            wb_rp_ff  <= '0;
            wb_cnt_ff <= '0;
        end else begin
            if (push) begin
                wb_wp_ff <= wb_wp_ff + 1'b1;
            end
            if (pop) begin
                wb_rp_ff <= wb_rp_ff + 1'b1;
            end
            if (push && !pop) begin
                wb_cnt_ff <= wb_cnt_ff + 1'b1;
            end else if (pop && !push) begin
                wb_cnt_ff <= wb_cnt_ff - 1'b1;
            end
        end
    end

    assign head      = wb_mem[wb_rp_ff];
    assign cand_wr   = wb_cnt_ff != '0;
    assign cand_rd   = !cand_wr && dp_rd_ff && !rd_done_ff;
    assign cand_bank = cand_wr ? head.bank : dp_bank_ff;
    // Turnaround on bank change or on a read followed by a write
    assign need_ta   = last_vld_ff && (cand_bank != last_bank_ff || (!last_wr_ff && cand_wr));

    assign ecfg      = cfg_ff[e_bank_ff];
    assign bus16     = ecfg[`STMC_F_BW16];
    assign last_part = bus16 ? {1'b0, e_size_ff == `STMC_SZ_WORD} :
                       (e_size_ff == `STMC_SZ_WORD ? 2'h3 : {1'b0, e_size_ff == `STMC_SZ_HALF});
    assign part_done = e_part_ff == last_part;
    assign ta_lim    = cfg_ff[last_bank_ff][`STMC_F_TA +: `STMC_W_TA];

    always_comb begin
        if (e_wr_ff) begin
            wait_lim = ecfg[`STMC_F_WRW +: `STMC_W_WAIT];
        end else if (ecfg[`STMC_F_BROM] && e_part_ff != 2'h0) begin
            wait_lim = ecfg[`STMC_F_BST +: `STMC_W_WAIT];
        end else begin
            wait_lim = ecfg[`STMC_F_RDW +: `STMC_W_WAIT];
        end
    end

    // Count reached and wait pin released
    assign wait_end = act_cnt_ff >= wait_lim && wait_s2_ff;
    assign next_wr  = !part_done || wb_cnt_ff > (PW + 1)'(1);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            stmc_pkg::S_IDLE: begin
                if (cand_wr || cand_rd) begin
                    nxt_state = need_ta ? stmc_pkg::S_TURN :
                                (cand_wr ? stmc_pkg::S_SETUP : stmc_pkg::S_ACT);
                end
            end
            stmc_pkg::S_TURN: begin
                if (ta_cnt_ff >= ta_lim) begin
                    nxt_state = e_wr_ff ? stmc_pkg::S_SETUP : stmc_pkg::S_ACT;
                end
            end
            stmc_pkg::S_SETUP: nxt_state = stmc_pkg::S_ACT;
            stmc_pkg::S_ACT: begin
                if (wait_end) begin
                    nxt_state = e_wr_ff ? stmc_pkg::S_REL : stmc_pkg::S_CAP;
                end
            end
            stmc_pkg::S_REL, stmc_pkg::S_CAP: begin
                nxt_state = part_done ? stmc_pkg::S_IDLE :
                            (e_wr_ff ? stmc_pkg::S_SETUP : stmc_pkg::S_ACT);
            end
            default: nxt_state = stmc_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= stmc_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            act_cnt_ff <= 5'h0;
            ta_cnt_ff  <= 4'h0;
        end else begin
            // Saturate so a long wait cannot wrap the count
            act_cnt_ff <= (state_ff == stmc_pkg::S_ACT && nxt_state == stmc_pkg::S_ACT) ?
                          (act_cnt_ff == '1 ? act_cnt_ff : act_cnt_ff + 5'h1) : 5'h0;
            ta_cnt_ff  <= (state_ff == stmc_pkg::S_TURN) ? ta_cnt_ff + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            e_wr_ff   <= 1'b0;
            e_bank_ff <= 2'h0;
            e_size_ff <= 2'h0;
            e_addr_ff <= 24'h0;
            e_data_ff <= 32'h0;
            e_part_ff <= 2'h0;
        end else if (state_ff == stmc_pkg::S_IDLE && (cand_wr || cand_rd)) begin
            e_wr_ff   <= cand_wr;
            e_bank_ff <= cand_bank;
            e_size_ff <= cand_wr ? head.size : dp_size_ff;
            e_addr_ff <= cand_wr ? head.addr : dp_addr_ff;
            e_data_ff <= head.data;
            e_part_ff <= 2'h0;
        end else if ((state_ff == stmc_pkg::S_REL || state_ff == stmc_pkg::S_CAP) && !part_done) begin
            e_part_ff <= e_part_ff + 2'h1;
            e_addr_ff <= e_addr_ff + (bus16 ? 24'h2 : 24'h1);
        end
    end

    assign pop = state_ff == stmc_pkg::S_REL && part_done;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_vld_ff  <= 1'b0;
            last_wr_ff   <= 1'b0;
            last_bank_ff <= 2'h0;
            rd_done_ff   <= 1'b0;
        end else begin
            rd_done_ff <= state_ff == stmc_pkg::S_CAP && part_done;
            if ((state_ff == stmc_pkg::S_REL || state_ff == stmc_pkg::S_CAP) && part_done) begin
                last_vld_ff  <= 1'b1;
                last_wr_ff   <= e_wr_ff;
                last_bank_ff <= e_bank_ff;
            end
        end
    end

    // Capture on the edge ending the wait
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_buf_ff <= 32'h0;
        end else if (state_ff == stmc_pkg::S_ACT && wait_end && !e_wr_ff) begin
            if (bus16) begin
                rd_buf_ff[{e_addr_ff[1], 4'h0} +: 16] <= ext_data_in;
            end else begin
                rd_buf_ff[{e_addr_ff[1:0], 3'h0} +: 8] <= ext_data_in[7:0];
            end
        end
    end

    always_comb begin
        if (bus16) begin
            wr_ble = e_size_ff != 2'h0 ? `STMC_BLE_ALL : (e_addr_ff[0] ? `STMC_BLE_HI : `STMC_BLE_LO);
        end else if (ecfg[`STMC_F_DW16]) begin
            wr_ble = e_addr_ff[0] ? `STMC_BLE_HI : `STMC_BLE_LO;
        end else begin
            wr_ble = `STMC_BLE_LO;
        end
        rd_ble = ecfg[`STMC_F_BLERD] ? `STMC_BLE_ALL : `STMC_BLE_NONE;
    end

    // Select drops early before a write
    assign cs_act = state_ff == stmc_pkg::S_ACT || state_ff == stmc_pkg::S_CAP ||
                    (state_ff == stmc_pkg::S_REL && !next_wr);

    for (genvar i = 0; i < `STMC_NUM_BANKS; i++) begin : g_cs
        if (i == 0) begin : g_b0
            assign bank_select_n[i] = !(cs_act && e_bank_ff == 2'(i));
        end else begin : g_bn
            assign bank_select_n[i] = !(cs_act && e_bank_ff == 2'(i) && cs_pin_en[i-1]);
        end
    end

    // Address only while a cycle runs
    assign ext_addr       = (state_ff == stmc_pkg::S_IDLE || state_ff == stmc_pkg::S_TURN) ? 24'h0 :
                            {addr_hi_pin_en ? e_addr_ff[23:16] : 8'h0, e_addr_ff[15:0]};
    assign write_strobe_n = !(state_ff == stmc_pkg::S_ACT && e_wr_ff);
    assign read_strobe_n  = !((state_ff == stmc_pkg::S_ACT || state_ff == stmc_pkg::S_CAP) && !e_wr_ff);
    assign ext_data_oe_n  = !(e_wr_ff && (state_ff == stmc_pkg::S_ACT || state_ff == stmc_pkg::S_REL));
    assign ext_data_out   = bus16 ? e_data_ff[{e_addr_ff[1], 4'h0} +: 16] :
                            {8'h0, e_data_ff[{e_addr_ff[1:0], 3'h0} +: 8]};
    assign byte_lane_n    = state_ff == stmc_pkg::S_ACT ? (e_wr_ff ? wr_ble : rd_ble) :
                            (state_ff == stmc_pkg::S_CAP ? rd_ble : `STMC_BLE_NONE);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence q_setup;
        state_ff == stmc_pkg::S_SETUP;
    endsequence

    sequence q_strobe;
        !write_strobe_n && !ext_data_oe_n && byte_lane_n != `STMC_BLE_NONE;
    endsequence

    sequence q_err_pair;
        hresp == `STMC_HRESP_ERR && !hreadyout ##1 hresp == `STMC_HRESP_ERR && hreadyout;
    endsequence

    a_wr_strobe: assert property (q_setup |=> q_strobe)
        else $error("write strobe missing after setup");

    a_bank0_sel: assert property (state_ff == stmc_pkg::S_ACT && e_bank_ff == 2'h0
        |-> bank_select_n == 4'he)
        else $error("bank 0 select wrong");

    a_hi_gated: assert property (!addr_hi_pin_en |-> ext_addr[23:16] == 8'h0)
        else $error("upper address driven while disabled");

    a_wait_min: assert property (state_ff == stmc_pkg::S_ACT && nxt_state != stmc_pkg::S_ACT
        |-> act_cnt_ff >= wait_lim)
        else $error("active phase ended early");

    a_wait_ext: assert property (state_ff == stmc_pkg::S_ACT && !wait_s2_ff
        |=> state_ff == stmc_pkg::S_ACT)
        else $error("wait input ignored");

    a_lane_release: assert property (state_ff == stmc_pkg::S_ACT && e_wr_ff && wait_end
        |=> byte_lane_n == `STMC_BLE_NONE && write_strobe_n ##1 ext_data_oe_n)
        else $error("lanes or data not released");

    a_wp_nowrite: assert property (ap_ok && ap_wp |=> !dp_wr_ff)
        else $error("protected write accepted");

    a_err_two: assert property (ap_err |=> q_err_pair)
        else $error("error response not two cycles");

    a_misalign_err: assert property (ap_ok && ap_mis |=> hresp == `STMC_HRESP_ERR)
        else $error("misaligned access not refused");

    a_post_write: assert property (dp_wr_ff && !wb_full |-> hreadyout)
        else $error("posted write stalled");

    a_ta_hold: assert property (state_ff == stmc_pkg::S_TURN && ta_cnt_ff < ta_lim
        |=> state_ff == stmc_pkg::S_TURN)
        else $error("turnaround cut short");

    a_rd_release: assert property (state_ff == stmc_pkg::S_CAP && part_done
        |-> (!bank_select_n[e_bank_ff] || e_bank_ff != 2'h0) ##1 (bank_select_n == 4'hf && rd_done_ff))
        else $error("read release timing wrong");

endmodule : stmc_static_mem_ctrl

/* sim/stmc_mem_model.sv */
// Purpose: External static memory behind the controller
// Assumes: Selects and strobes active low
// Notes:   Undriven data bus shows a changing pattern
`timescale 1ns/1ps
module stmc_mem_model (
    input  wire logic        clock,
    input  wire logic        slow,
    input  wire logic [23:0] ext_addr,
    input  wire logic [15:0] ext_data_out,
    output logic      [15:0] ext_data_in,
    input  wire logic [3:0]  bank_select_n,
    input  wire logic [1:0]  byte_lane_n,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    output logic             extend_wait_n
);
    logic [15:0] mem [0:511];
    logic [15:0] last_q = 16'h0;
    logic [1:0]  bank;
    logic        sel;
    logic        we_q = 1'b1;
    logic [23:0] wr_addr = 24'h0;
    logic [23:0] prev_addr = 24'h0;
    int          sel_cnt = 0;
    int          wr_cnt = 0;
    int          str_len = 0;
    logic [1:0]  wr_ble = 2'h3;
    logic        wseen = 1'b0;
    int          w_last_run = 0;
    int          w_prev_run = 0;
    assign sel = bank_select_n != 4'hf;
    assign bank = !bank_select_n[0] ? 2'h0 : !bank_select_n[1] ? 2'h1 : !bank_select_n[2] ? 2'h2 : 2'h3;
    assign ext_data_in = (sel && !read_strobe_n) ? mem[{bank, ext_addr[6:0]}] : ~last_q;
    assign extend_wait_n = !(slow && sel && sel_cnt < 8);
    always @(posedge clock) begin
        last_q <= ext_data_in;
        sel_cnt <= sel ? sel_cnt + 1 : 0;
        we_q <= write_strobe_n;
        if (sel && !write_strobe_n) begin
            mem[{bank, ext_addr[6:0]}] <= ext_data_out;
            str_len <= we_q ? 1 : str_len + 1;
            wr_ble <= byte_lane_n;
        end
        // Select run lengths of write cycles
        wseen <= sel && (wseen || !write_strobe_n);
        if (!sel && sel_cnt != 0 && wseen) begin
            w_prev_run <= w_last_run;
            w_last_run <= sel_cnt;
        end
        if (sel && !write_strobe_n && we_q) begin
            wr_cnt <= wr_cnt + 1;
            prev_addr <= wr_addr;
            wr_addr <= ext_addr;
        end
    end
endmodule : stmc_mem_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the static memory controller
// Assumes: Single bus master, hready fed back from hreadyout
// Notes:   Expected data follow the bank configs below
`timescale 1ns/1ps
`include "stmc_consts.svh"
module tb_top;
    logic        clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout;
    logic [1:0]  htrans = 2'h0, hresp, byte_lane_n, rs;
    logic [2:0]  hsize = 3'h0, cs_pin_en = 3'h7;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, reg_wdata = 32'h0, reg_rdata, rd, rv;
    logic [7:0]  reg_addr = 8'h0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, boot_x8 = 1'b0, addr_hi_pin_en = 1'b1, slow = 1'b0;
    logic [23:0] ext_addr;
    logic [15:0] ext_data_out, ext_data_in;
    logic        ext_data_oe_n, write_strobe_n, read_strobe_n, extend_wait_n;
    logic [3:0]  bank_select_n;
    logic [31:0] cfg [4] = '{32'h0018_0000, 32'h0018_0040, 32'h0038_0000, 32'h0000_0042};
    int          n_errors = 0, samples_checked = 0, n_wait, c0;
    assign hready = hreadyout;
    always #2 clock = ~clock;
    stmc_static_mem_ctrl uut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .boot_x8(boot_x8), .cs_pin_en(cs_pin_en), .addr_hi_pin_en(addr_hi_pin_en),
        .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
        .ext_data_in(ext_data_in), .bank_select_n(bank_select_n), .byte_lane_n(byte_lane_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .extend_wait_n(extend_wait_n));
    stmc_mem_model mem (.clock(clock), .slow(slow), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_in(ext_data_in), .bank_select_n(bank_select_n), .byte_lane_n(byte_lane_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .extend_wait_n(extend_wait_n));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic do_reset(input logic x8);
        @(posedge clock);
        reset_n <= 1'b0;
        boot_x8 <= x8;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : do_reset
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rv = reg_rdata;
    endtask : rreg
    task automatic wait_rdy;
        n_wait = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1 && n_wait < 300) begin
            @(negedge clock);
            n_wait++;
        end
        check(hreadyout, 1'b1);
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rs = hresp;
        rd = hrdata;
    endtask : ahb
    initial begin
        #80000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        @(negedge clock);
        check({bank_select_n, write_strobe_n, read_strobe_n, ext_data_oe_n, hreadyout, byte_lane_n, hresp},
              12'hffc);
        do_reset(1'b0);
        rreg(8'h00);
        check(rv, `STMC_CFG_RESET);
        rreg(8'h14);
        check(rv, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wreg(8'(k * 4), cfg[k]);
            rreg(8'(k * 4));
            check(rv, cfg[k]);
        end
        $display("test config done");
        ahb(1'b1, 32'hf700_0020, 3'h2, 32'h1234_5678);
        check(rs, `STMC_HRESP_OK);
        check(n_wait, 0);
        ahb(1'b0, 32'hf700_0020, 3'h2, 32'h0);
        check(rd, 32'h1234_5678);
        check(mem.prev_addr, 24'h20);
        check(mem.wr_addr, 24'h22);
        check(mem.w_prev_run, 3);
        check(mem.w_last_run, 4);
        check(mem.wr_ble, 2'h0);
        check(mem.mem[{2'h1, 7'h20}], 16'h5678);
        check(mem.str_len, 3);
        $display("test split write done");
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, 32'h0000_0040 + i * 2, 3'h1, {2{16'ha000 + 16'(i)}});
            check(n_wait, 0);
        end
        ahb(1'b0, 32'h0000_0046, 3'h1, 32'h0);
        check(rd[31:16], 16'ha003);
        check(mem.mem[{2'h0, 7'h40}], 16'ha000);
        $display("test posted writes done");
        for (int i = 0; i < 4; i++) begin
            c0 = mem.wr_cnt;
            case (i)
                0: ahb(1'b1, 32'h0800_0000, 3'h1, 32'h0);
                1: ahb(1'b0, 32'h0000_0011, 3'h1, 32'h0);
                2: ahb(1'b1, 32'h0000_0002, 3'h2, 32'h0);
                default: ahb(1'b1, 32'h0000_0000, 3'h3, 32'h0);
            endcase
            check(rs, `STMC_HRESP_ERR);
            check(n_wait, 1);
            repeat (8) @(negedge clock);
            check(mem.wr_cnt, c0);
        end
        $display("test errors done");
        slow <= 1'b1;
        ahb(1'b1, 32'h0c00_0000, 3'h2, 32'hcafe_f00d);
        ahb(1'b0, 32'h0c00_0000, 3'h2, 32'h0);
        check(rd, 32'hcafe_f00d);
        check(mem.wr_addr, 24'h3);
        check(mem.wr_ble, 2'h2);
        check(mem.str_len >= 8, 1'b1);
        slow <= 1'b0;
        $display("test slow byte bank done");
        do_reset(1'b1);
        rreg(8'h00);
        check(rv, `STMC_CFG_RESET & ~(32'h1 << `STMC_F_BW16));
        @(posedge clock);
        addr_hi_pin_en <= 1'b0;
        ahb(1'b1, 32'h00ab_0010, 3'h1, 32'h0000_5aa5);
        ahb(1'b0, 32'h00ab_0010, 3'h1, 32'h0);
        check(rd[15:0], 16'h5aa5);
        check(mem.wr_addr, 24'h11);
        $display("test boot width done");
        report_and_stop();
    end
endmodule : tb_top
